/* File: hdl/cs_pkg.sv */
// Purpose: Constants and carriers for chip-select and bus termination
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   Chip-select configuration travels as one packed struct per select
package cs_pkg;
    localparam int NUM_CS       = 4;
    localparam int BOOT_CS      = 0;
    localparam int ADDR_W       = 24;
    localparam int CMP_LSB      = 11;
    localparam int CMP_W        = ADDR_W - CMP_LSB;
    localparam int WAIT_W       = 4;
    localparam int TMO_W        = 8;
    // Clock rate and per-wait-state period
    localparam int CLK_MHZ      = 100;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    // A wait state is one clock period, whatever the rate
    localparam int WAIT_STATE_NS = CLK_PERIOD_NS;
    localparam int WAIT_STATE_CYC =
        (WAIT_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Base cycle lengths, in clocks
    localparam int ZERO_WAIT_CYC = 3;
    localparam int FAST_TERM_CYC = 2;
    localparam logic [WAIT_W-1:0] BOOT_WAITS = 4'hD;
    localparam logic [TMO_W-1:0]  TMO_DEFAULT = 8'h40;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_ONE  = 4'h1;
    localparam logic [TMO_W-1:0]  TMO_ZERO  = 8'h00;
    localparam logic [TMO_W-1:0]  TMO_ONE   = 8'h01;

    typedef enum logic [1:0] {
        SIZE_NONE = 2'h0,
        SIZE_8    = 2'h1,
        SIZE_16   = 2'h2
    } port_size_e;

    typedef struct packed {
        logic              enable;
        logic [CMP_W-1:0]  base;
        logic [CMP_W-1:0]  mask;      // 1 = compared address bit
        logic              port16;
        logic              upper;
        logic              lower;
        logic              rd_en;
        logic              wr_en;
        logic              on_ds;     // 0 = address strobe, 1 = data strobe
        logic              fast;      // fast termination
        logic              sp_check;
        logic [1:0]        space;
        logic [WAIT_W-1:0] waits;
    } cs_cfg_s;

    localparam cs_cfg_s CFG_OFF = '0;
    localparam cs_cfg_s CFG_BOOT = '{
        enable: 1'b1, base: '0, mask: '0, port16: 1'b1,
        upper: 1'b1, lower: 1'b1, rd_en: 1'b1, wr_en: 1'b1,
        on_ds: 1'b0, fast: 1'b0, sp_check: 1'b0, space: 2'h0,
        waits: BOOT_WAITS};

    typedef struct packed {
        logic              as;
        logic              ds;
        logic              rw;        // 1 = read
        logic              upper;
        logic              lower;
        logic [1:0]        space;
        logic [ADDR_W-1:0] addr;
    } bus_req_s;
endpackage

/* File: hdl/cs_match.sv */
// Purpose: Address and qualifier match of one chip select
// Assumes: Bus request stable during the access
// Notes:   Pure combinational compare
`timescale 1ns/10ps
module cs_match (
    input  cs_pkg::cs_cfg_s  cfg,
    input  cs_pkg::bus_req_s req,
    output logic             hit
);
    logic [cs_pkg::CMP_W-1:0] a_hi;
    logic                     a_ok;
    logic                     q_ok;

    always_comb begin
        a_hi = req.addr[cs_pkg::ADDR_W-1:cs_pkg::CMP_LSB];
        a_ok = ((a_hi ^ cfg.base) & cfg.mask) == '0;
        q_ok = (cfg.on_ds ? req.ds : req.as)
             & (req.rw ? cfg.rd_en : cfg.wr_en)
             & ((req.upper & cfg.upper) | (req.lower & cfg.lower))
             & (!cfg.sp_check || (req.space == cfg.space));
        hit  = cfg.enable & a_ok & q_ok;
    end
endmodule // cs_match

/* File: hdl/cs_term.sv */
// Purpose: Chip selects, size acknowledge, bus monitor, double-fault reset
// Assumes: Configuration ports come from software-written storage
// Notes:   Outputs held inactive during reset except boot defaults
//
// Overview of operation
// - Bus cycle stays open until a size acknowledge, an external acknowledge or a bus fault.
// - A matching chip select drives the size acknowledge itself.
// - Each non-fast select delays its acknowledge by its programmed wait count.
// - Each wait state adds exactly one clock period.
// - Bus monitor raises bus fault on timeout; default 64 cycles.
// - Bus fault on two consecutive cycles forces a device reset.
// - Bus monitor is disabled after reset.
// - Only the boot select is active after reset.
// - Boot select: address strobe, both halves, read/write, 13 waits.
// - Qualify by strobe and space; compare A23..A11 to base.
// - Unmatched access gets no acknowledge from this logic.
// - Zero waits leave the memory the full selected window.
// - Zero-wait access is three clocks; fast termination two.
// - Base at 2 KB granularity; 8- or 16-bit port width.
`timescale 1ns/10ps
module cs_term (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  cs_pkg::bus_req_s                      req,
    input  wire logic                             ext_ack,
    input  wire logic                             cfg_we,
    input  wire logic [$clog2(cs_pkg::NUM_CS)-1:0] cfg_idx,
    input  cs_pkg::cs_cfg_s                       cfg_wdata,
    input  wire logic                             mon_en_we,
    input  wire logic                             mon_en_wdata,
    input  wire logic                             tmo_we,
    input  wire logic [cs_pkg::TMO_W-1:0]         tmo_wdata,
    output logic [cs_pkg::NUM_CS-1:0]             cs_n,
    output cs_pkg::port_size_e                    size_acknowledge,
    output logic                                  bus_fault,
    output logic                                  force_reset,
    output logic                                  cycle_done,
    output logic                                  mon_en
);
    // ****************************************
    // State record
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_END} state_e;

    typedef struct packed {
        cs_pkg::cs_cfg_s [cs_pkg::NUM_CS-1:0] cfg;
        state_e                               st;
        logic [cs_pkg::NUM_CS-1:0]            sel;
        logic [cs_pkg::WAIT_W:0]              cnt;
        logic [cs_pkg::TMO_W-1:0]             tmo_cnt;
        logic [cs_pkg::TMO_W-1:0]             tmo;
        logic                                 mon_en;
        logic                                 last_fault;
        cs_pkg::port_size_e                   ack;
        logic                                 fault;
        logic                                 frst;
        logic                                 done;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic [cs_pkg::NUM_CS-1:0] hit;
    logic                      any_hit;
    logic [cs_pkg::NUM_CS-1:0] win;
    logic [cs_pkg::WAIT_W:0]   need;
    logic                      fast_sel;
    logic                      port16_sel;
    logic                      end_cycle;

    // ****************************************
    // Address match, one compare per select
    // ****************************************
    // Each compare sees the live request, so a hit follows the bus
    genvar g;
    generate
        for (g = 0; g < cs_pkg::NUM_CS; g++) begin : g_cs
            cs_match u_match (
                .cfg (st_r.cfg[g]),
                .req (req),
                .hit (hit[g])
            );
        end
    endgenerate

    // ****************************************
    // Priority among overlapping selects
    // ****************************************
    // Lowest index wins when regions overlap, so two
    // devices never drive the data bus at once
    always_comb begin
        any_hit    = |hit;
        win        = '0;
        need       = '0;
        fast_sel   = 1'b0;
        port16_sel = 1'b0;
        for (int i = cs_pkg::NUM_CS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                win        = '0;
                win[i]     = 1'b1;
                // one wait state is WAIT_STATE_CYC clocks
                need       = (cs_pkg::WAIT_W + 1)'(st_r.cfg[i].waits
                             * cs_pkg::WAIT_STATE_CYC);
                fast_sel   = st_r.cfg[i].fast;
                port16_sel = st_r.cfg[i].port16;
            end
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt      = st_r;
        st_nxt.ack  = cs_pkg::SIZE_NONE;
        st_nxt.fault = 1'b0;
        st_nxt.frst = 1'b0;
        st_nxt.done = 1'b0;
        end_cycle   = 1'b0;
        if (cfg_we) begin
            st_nxt.cfg[cfg_idx] = cfg_wdata;
        end
        if (mon_en_we) begin
            st_nxt.mon_en = mon_en_wdata;
        end
        if (tmo_we) begin
            st_nxt.tmo = tmo_wdata;
        end
        case (st_r.st)
            // Monitor counts from the take edge; zero timeout is off
            ST_IDLE: begin
                st_nxt.tmo_cnt = cs_pkg::TMO_ONE;
                if (req.as) begin
                    st_nxt.sel = win;
                    st_nxt.cnt = '0;
                    st_nxt.st  = ST_WAIT;
                end
            end
            ST_WAIT: begin
                st_nxt.sel     = st_r.sel & hit;
                st_nxt.tmo_cnt = st_r.tmo_cnt + cs_pkg::TMO_ONE;
                st_nxt.cnt     = st_r.cnt + 1'b1;
                if (!req.as) begin
                    st_nxt.st  = ST_IDLE;
                    st_nxt.sel = '0;
                end else if (any_hit && (fast_sel
                             || st_r.cnt > need)) begin
                    // normal ack trails fast by a clock
                    // giving three clocks at zero waits against two
                    st_nxt.ack = port16_sel ? cs_pkg::SIZE_16
                                            : cs_pkg::SIZE_8;
                    end_cycle  = 1'b1;
                end else if (!any_hit && ext_ack) begin
                    end_cycle  = 1'b1;
                end else if (st_r.mon_en && st_r.tmo != cs_pkg::TMO_ZERO
                             && st_r.tmo_cnt >= st_r.tmo) begin
                    st_nxt.fault = 1'b1;
                    end_cycle    = 1'b1;
                    if (st_r.last_fault) begin
                        st_nxt.frst = 1'b1;
                    end
                end
                if (end_cycle) begin
                    st_nxt.done       = 1'b1;
                    st_nxt.last_fault = st_nxt.fault;
                    st_nxt.sel        = '0;
                    st_nxt.st         = ST_END;
                end
            end
            ST_END: begin
                // Wait for the strobe to drop before a new cycle;
                // taking it again here would repeat the same access
                st_nxt.sel = '0;
                if (!req.as) begin
                    st_nxt.st = ST_IDLE;
                end
            end
            default: begin
                st_nxt.st = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    // Whole record cleared first; boot select then gets its defaults
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r            <= '0;
            for (int i = 0; i < cs_pkg::NUM_CS; i++) begin
                st_r.cfg[i] <= cs_pkg::CFG_OFF;
            end
            st_r.cfg[cs_pkg::BOOT_CS] <= cs_pkg::CFG_BOOT;
            st_r.st         <= ST_IDLE;
            st_r.tmo        <= cs_pkg::TMO_DEFAULT;
            st_r.mon_en     <= 1'b0;
            st_r.ack        <= cs_pkg::SIZE_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Select held from match through last wait state
    assign cs_n             = ~st_r.sel;
    assign size_acknowledge = st_r.ack;
    assign bus_fault        = st_r.fault;
    assign force_reset      = st_r.frst;
    assign cycle_done       = st_r.done;
    assign mon_en           = st_r.mon_en;
endmodule // cs_term

/* File: bench/cs_term_sva.sv */
// Purpose: Port-level checks of chip selects and bus termination
// Assumes: One clock, synchronous active-low reset
// Notes:   Configuration ports are not watched
`timescale 1ns/10ps
module cs_term_sva (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input cs_pkg::bus_req_s           req,
    input wire logic [cs_pkg::NUM_CS-1:0] cs_n,
    input cs_pkg::port_size_e         size_acknowledge,
    input wire logic                  bus_fault,
    input wire logic                  cycle_done,
    input wire logic                  mon_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence sel_start_s;
        $fell(&cs_n);
    endsequence
    // Fifteen waits plus two base clocks at most
    sequence acked_s;
        ##[1:17] size_acknowledge != cs_pkg::SIZE_NONE;
    endsequence
    a_select_acked: assert property (sel_start_s |-> acked_s)
        else $error("select not acknowledged in time");
    a_ack_from_select: assert property (
        size_acknowledge != cs_pkg::SIZE_NONE |-> $past(cs_n) != '1)
        else $error("acknowledge without a select");
    a_ack_ends_select: assert property (
        size_acknowledge != cs_pkg::SIZE_NONE |-> cycle_done && (&cs_n))
        else $error("select outlives its acknowledge");
    a_done_on_strobe: assert property (cycle_done |-> $past(req.as))
        else $error("cycle ended without a strobe");
    a_select_on_strobe: assert property (
        !(&cs_n) |-> $past(req.as))
        else $error("select without a strobe");
    a_one_select: assert property ($onehot0(~cs_n))
        else $error("two selects at once");
    a_reset_quiet: assert property (
        !$past(rst_n) |-> (&cs_n) && !mon_en)
        else $error("outputs active just after reset");
    a_fault_needs_mon: assert property (bus_fault |-> $past(mon_en))
        else $error("bus fault with monitor off");
endmodule // cs_term_sva
bind cs_term cs_term_sva i_cs_term_sva (.clk(clk), .rst_n(rst_n),
    .req(req), .cs_n(cs_n), .size_acknowledge(size_acknowledge),
    .bus_fault(bus_fault), .cycle_done(cycle_done), .mon_en(mon_en));

/* File: bench/ext_dev.sv */
// Purpose: External peripheral answering unmatched accesses
// Assumes: Strobe held until the cycle ends
// Notes:   Silent while en is low, to provoke the bus monitor
`timescale 1ns/10ps
module ext_dev #(
    parameter int DELAY = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic as,
    input wire logic en,
    output logic     ext_ack
);
    logic [7:0] cnt_r;
    always_ff @(posedge clk) begin
        if (!rst_n || !as) begin
            cnt_r <= 8'h00;
            ext_ack <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            ext_ack <= en && (cnt_r >= DELAY[7:0]);
        end
    end
endmodule // ext_dev

/* File: bench/chip_select_bus_termination_tb_top.sv */
// Purpose: Directed bus cycles through the chip-select block
// Assumes: Inputs change at the falling edge
// Notes:   Latency counts the take edge as one
`timescale 1ns/10ps
module chip_select_bus_termination_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cs_pkg::bus_req_s req = '0;
    logic cfg_we = 1'b0;
    logic [1:0] cfg_idx = 2'h0;
    cs_pkg::cs_cfg_s cfg_wdata = '0;
    logic mon_en_we = 1'b0;
    logic mon_en_wdata = 1'b0;
    logic tmo_we = 1'b0;
    logic [7:0] tmo_wdata = 8'h00;
    logic dev_en = 1'b1;
    logic ext_ack, bus_fault, force_reset, cycle_done, mon_en;
    logic [3:0] cs_n, cs_seen;
    cs_pkg::port_size_e size_acknowledge, ack_seen;
    logic fault_seen;
    int n_mismatch = 0, cmp_count = 0, fr_cnt = 0, lat;
    cs_term i_cs_term (.clk(clk), .rst_n(rst_n), .req(req),
        .ext_ack(ext_ack), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
        .cfg_wdata(cfg_wdata), .mon_en_we(mon_en_we),
        .mon_en_wdata(mon_en_wdata), .tmo_we(tmo_we),
        .tmo_wdata(tmo_wdata), .cs_n(cs_n),
        .size_acknowledge(size_acknowledge), .bus_fault(bus_fault),
        .force_reset(force_reset), .cycle_done(cycle_done),
        .mon_en(mon_en));
    ext_dev #(.DELAY(5)) i_ext_dev (.clk(clk), .rst_n(rst_n),
        .as(req.as), .en(dev_en), .ext_ack(ext_ack));
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (force_reset === 1'b1) fr_cnt++;
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic set_cfg(input logic [1:0] idx, input cs_pkg::cs_cfg_s c);
        cfg_we = 1'b1;
        cfg_idx = idx;
        cfg_wdata = c;
        @(negedge clk);
        cfg_we = 1'b0;
        // Idle clock between writes keeps each strobe a clean pulse
        @(negedge clk);
    endtask
    function automatic cs_pkg::cs_cfg_s mk(input logic p16, input logic f,
                                           input logic [3:0] w);
        mk = cs_pkg::CFG_BOOT;
        mk.base = 13'h0100;
        mk.mask = 13'h1FE0;
        mk.port16 = p16;
        mk.fast = f;
        mk.waits = w;
    endfunction
    // One whole cycle; latency below zero means not compared
    task automatic run(input logic [23:0] a, input int lat_e,
        input logic [3:0] cs_e, input cs_pkg::port_size_e ack_e,
        input logic f_e);
        req = '{as: 1'b1, ds: 1'b1, rw: 1'b1, upper: 1'b1, lower: 1'b1,
                space: 2'h1, addr: a};
        lat = 0;
        cs_seen = 4'hF;
        fault_seen = 1'b0;
        ack_seen = cs_pkg::SIZE_NONE;
        for (int i = 0; i < 300 && !(cycle_done === 1'b1 || fault_seen);
             i++) begin
            @(posedge clk);
            #1;
            lat++;
            cs_seen &= cs_n;
            ack_seen = size_acknowledge;
            fault_seen = (bus_fault === 1'b1);
        end
        if (lat >= 300) begin
            n_mismatch++;
            end_sim();
        end
        if (lat_e < 0) lat = lat_e;
        chk({lat[7:0], cs_seen, ack_seen, fault_seen},
            {lat_e[7:0], cs_e, ack_e, f_e});
        @(negedge clk);
        req.as = 1'b0;
        req.ds = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        cs_pkg::cs_cfg_s q;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk({8'h00, cs_n, size_acknowledge, mon_en}, 15'h78);
        run(24'hABCDEF, 16, 4'hE, cs_pkg::SIZE_16, 1'b0);
        set_cfg(2'h0, cs_pkg::CFG_OFF);
        set_cfg(2'h2, mk(1'b1, 1'b1, 4'h0));
        // Overlapping selects 1 and 2: the lower index must win
        for (int w = 0; w < 16; w += 5) begin
            set_cfg(2'h1, mk(1'b0, 1'b0, 4'(w)));
            run(24'h08FFFE, 3+w, 4'hD, cs_pkg::SIZE_8, 1'b0);
        end
        set_cfg(2'h1, cs_pkg::CFG_OFF);
        run(24'h080000, 2, 4'hB, cs_pkg::SIZE_16, 1'b0);
        // Space qualifier mismatch: only the external device answers
        q = mk(1'b1, 1'b1, 4'h0);
        q.sp_check = 1'b1;
        q.space = 2'h2;
        set_cfg(2'h2, q);
        run(24'h080000, 7, 4'hF, cs_pkg::SIZE_NONE, 1'b0);
        q.space = 2'h1;
        q.on_ds = 1'b1;
        set_cfg(2'h2, q);
        run(24'h080000, 2, 4'hB, cs_pkg::SIZE_16, 1'b0);
        run(24'h07FFFE, 7, 4'hF, cs_pkg::SIZE_NONE, 1'b0);
        dev_en = 1'b0;
        mon_en_we = 1'b1;
        mon_en_wdata = 1'b1;
        @(negedge clk);
        mon_en_we = 1'b0;
        run(24'h090000, 65, 4'hF, cs_pkg::SIZE_NONE, 1'b1);
        run(24'h080000, 2, 4'hB, cs_pkg::SIZE_16, 1'b0);
        tmo_we = 1'b1;
        tmo_wdata = 8'h08;
        @(negedge clk);
        tmo_we = 1'b0;
        run(24'h090000, 9, 4'hF, cs_pkg::SIZE_NONE, 1'b1);
        run(24'h090000, 9, 4'hF, cs_pkg::SIZE_NONE, 1'b1);
        chk(15'(fr_cnt), 15'h0001);
        end_sim();
    end
endmodule // chip_select_bus_termination_tb_top
